// >>> logic/ird_pkg.sv
// Purpose: shared constants and types of the range, io line and dac control bank
// Assumes: 40 MHz core clock
// Notes: byte addresses are the upper byte of a command word without its top bit
`default_nettype none
package ird_pkg;
  // =======================================
  // timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int DR_PULSE_NS = 150000;
  localparam int DR_PULSE_CYCLES = DR_PULSE_NS / CLK_PERIOD_NS;
  localparam int TB_FAST_NS = 610350;
  localparam int TB_FAST_CYCLES = TB_FAST_NS / CLK_PERIOD_NS;
  localparam int TB_SLOW_NS = 18921000;
  localparam int TB_SLOW_CYCLES = TB_SLOW_NS / CLK_PERIOD_NS;
  localparam int SELF_TEST_CYCLES = 2000;
  localparam int FLASH_TEST_CYCLES = 1000;
  // =======================================
  // byte addresses, even byte is the low byte
  localparam logic [6:0] ADDR_ANALOG_OUT = 7'h30;
  localparam logic [6:0] ADDR_IO_LINE = 7'h32;
  localparam logic [6:0] ADDR_MISC = 7'h34;
  localparam logic [6:0] ADDR_SAMPLE = 7'h36;
  localparam logic [6:0] ADDR_RANGE_TAPS = 7'h38;
  localparam logic [6:0] ADDR_GLOBAL = 7'h3E;
  // =======================================
  // reset values and implemented bits
  localparam logic [15:0] RST_RANGE_TAPS = 16'h0402;
  localparam logic [15:0] RST_IO_LINE = 16'h0000;
  localparam logic [15:0] RST_MISC = 16'h0006;
  localparam logic [15:0] RST_ANALOG_OUT = 16'h0000;
  localparam logic [15:0] RST_SAMPLE = 16'h0001;
  localparam logic [15:0] RST_GLOBAL = 16'h0000;
  localparam logic [15:0] MASK_RANGE_TAPS = 16'h0707;
  localparam logic [15:0] MASK_IO_LINE = 16'h0F0F;
  localparam logic [15:0] MASK_MISC = 16'h0FC7;
  localparam logic [15:0] MASK_ANALOG_OUT = 16'h0FFF;
  localparam logic [15:0] MASK_SAMPLE = 16'h00FF;
  localparam logic [15:0] MASK_GLOBAL = 16'h009F;
  // pin synchroniser reset: {io_in[3:0], mosi, cs_n, sclk}
  localparam logic [6:0] SYNC_RST = 7'h03;
  // =======================================
  // field positions
  localparam int RANGE_LSB = 8;
  localparam int IO_LEVEL_LSB = 8;
  localparam int IO_LINE_FOUR = 3;
  localparam int MISC_DR_SEL = 0;
  localparam int MISC_DR_POL = 1;
  localparam int MISC_DR_EN = 2;
  localparam int MISC_ACCEL_ALIGN = 6;
  localparam int MISC_LIN_BIAS = 7;
  localparam int MISC_ST_POS = 8;
  localparam int MISC_ST_NEG = 9;
  localparam int MISC_SELF_TEST = 10;
  localparam int GLOBAL_DAC_LATCH = 2;
  localparam int SAMPLE_BASE = 7;
  // =======================================
  // range codes and tap floors
  localparam logic [2:0] RANGE_CODE_WIDE = 3'h4;
  localparam logic [2:0] RANGE_CODE_MID = 3'h2;
  localparam logic [2:0] RANGE_CODE_NARROW = 3'h1;
  localparam logic [2:0] TAPS_MIN_MID = 3'h2;
  localparam logic [2:0] TAPS_MIN_NARROW = 3'h4;
  localparam logic [2:0] TAPS_MIN_NONE = 3'h0;

  typedef struct packed {
    logic wr;
    logic [6:0] addr;
    logic [7:0] data;
  } ird_cmd_t;

  typedef enum logic [1:0] {
    RANGE_WIDE,
    RANGE_MID,
    RANGE_NARROW,
    RANGE_BAD
  } ird_range_t;
endpackage
`default_nettype wire

// >>> logic/ird_pulse_gen.sv
// Purpose: fixed width data-ready pulse per sample trigger
// Assumes: trigger is a one-cycle pulse on core_clk
// Notes: triggers during a pulse are ignored so the width never stretches
`default_nettype none
module ird_pulse_gen #(
  parameter int PULSE_CYCLES = ird_pkg::DR_PULSE_CYCLES
) (
  input wire logic core_clk, // system clock
  input wire logic rst_n, // synchronised reset, low active
  input wire logic trigger, // sample event
  output logic pulse // high for the pulse length
);
  // =======================================
  // width counter
  localparam logic [15:0] LAST = 16'(PULSE_CYCLES - 1);
  logic pulse_q;
  logic [15:0] cnt_q;
  logic [15:0] width_q;
  wire logic at_last = cnt_q == LAST;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_q <= 1'b0;
      cnt_q <= 16'h0000;
    end else if (pulse_q) begin
      pulse_q <= !at_last;
      cnt_q <= at_last ? 16'h0000 : cnt_q + 16'h0001;
    end else begin
      pulse_q <= trigger;
      cnt_q <= 16'h0000;
    end
  end
  assign pulse = pulse_q;

  // =======================================
  // checks
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      width_q <= 16'h0000;
    end else begin
      width_q <= pulse_q ? width_q + 16'h0001 : 16'h0000;
    end
  end

  a_pulse_width: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    $fell(pulse_q) |-> $past(width_q) == LAST)
    else $error("data-ready pulse width wrong");

  a_pulse_bound: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    pulse_q |-> width_q <= LAST)
    else $error("data-ready pulse too long");
endmodule
`default_nettype wire

// >>> logic/ird_io_range_dac_control.sv
// Purpose: configuration bank behind a 16-bit spi command port
// Assumes: spi mode 3, sclk well below core_clk / 8
// Notes: read data comes back in the word after the read command
// Notes on behaviour
// - range field 100 widest and reset, 010 middle, 001 narrowest.
// - middle range forces taps at least 2, narrowest at least 4.
// - tap field M gives each of two stages two to the M taps.
// - line ownership: misc control, then alarm, then io line control.
// - io control low four bits set line direction, 1 output.
// - io control bits 11 to 8 hold levels driven on output lines.
// - line four input plus sample period zero selects external sample clock.
// - after reset data-ready is active high on line one, misc 0x0006.
// - misc bit 2 enable, bit 1 polarity, bit 0 selects line two.
// - each data-ready pulse lasts between 100 and 200 microseconds.
// - misc bit 11 starts flash test, cleared by device when done.
// - misc bit 10 starts self-test, cleared by device when done.
// - misc bit 9 negative, bit 8 positive manual stimulus, both held.
// - misc bit 7 enables bias compensation, bit 6 origin alignment.
// - low twelve bits of analog out are an offset binary dac code.
// - latch command copies the low twelve bits of analog out to the dac.
// - global command bits start on 1 and clear after completion.
`default_nettype none
module ird_io_range_dac_control #(
  parameter int DR_PULSE_CYCLES = ird_pkg::DR_PULSE_CYCLES,
  parameter int TB_FAST_CYCLES = ird_pkg::TB_FAST_CYCLES,
  parameter int TB_SLOW_CYCLES = ird_pkg::TB_SLOW_CYCLES
) (
  input wire logic core_clk, // 40 MHz clock
  input wire logic reset_n, // async reset, low active
  input wire logic spi_sclk, // serial clock pin
  input wire logic spi_cs_n, // chip select pin, low active
  input wire logic spi_mosi, // serial data in
  output logic spi_miso, // serial data out
  input wire logic [3:0] io_in, // io line pin levels
  output logic [3:0] io_out, // io line drive levels
  output logic [3:0] io_oe_n, // io line drive enables, low active
  input wire logic [3:0] alarm_own, // alarm logic claims line
  input wire logic [3:0] alarm_level, // alarm drive levels
  output ird_pkg::ird_range_t gyro_range, // decoded range
  output logic [7:0] stage_taps, // taps per stage
  output logic st_neg_en, // negative manual stimulus
  output logic st_pos_en, // positive manual stimulus
  output logic lin_bias_comp_en, // bias compensation enable
  output logic accel_align_en, // origin alignment enable
  output logic self_test_busy, // self-test running
  output logic flash_test_busy, // flash test running
  output logic [7:0] global_pulse, // started global commands
  output logic [11:0] dac_code, // latched dac code
  output logic sample_tick // one pulse per sample
);
  // =======================================
  // reset release
  logic [1:0] rst_sync_q;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  wire logic rst_n = rst_sync_q[1];

  // =======================================
  // pin synchronisers, value taken when stages b and c agree
  wire logic [6:0] pin_raw = {io_in, spi_mosi, spi_cs_n, spi_sclk};
  logic [6:0] sync_a_q;
  logic [6:0] sync_b_q;
  logic [6:0] sync_c_q;
  logic [6:0] pin_q;
  wire logic [6:0] agree = sync_b_q ~^ sync_c_q;
  wire logic [6:0] pin_d = (agree & sync_c_q) | (~agree & pin_q);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_a_q <= ird_pkg::SYNC_RST;
      sync_b_q <= ird_pkg::SYNC_RST;
      sync_c_q <= ird_pkg::SYNC_RST;
      pin_q <= ird_pkg::SYNC_RST;
    end else begin
      sync_a_q <= pin_raw;
      sync_b_q <= sync_a_q;
      sync_c_q <= sync_b_q;
      pin_q <= pin_d;
    end
  end

  // =======================================
  // spi shifter, 16-bit words, several per select allowed
  logic sclk_prev_q;
  logic cs_prev_q;
  logic [15:0] shift_in_q;
  logic [15:0] shift_out_q;
  logic [15:0] reply_q;
  logic [3:0] bit_cnt_q;
  logic miso_q;
  logic cmd_valid_q;
  wire logic cs_act = !pin_q[1];
  wire logic cs_fall = cs_act && cs_prev_q;
  wire logic sclk_rise = cs_act && pin_q[0] && !sclk_prev_q;
  wire logic sclk_fall = cs_act && !pin_q[0] && sclk_prev_q;
  wire logic word_done = sclk_rise && bit_cnt_q == 4'hF;
  wire logic [15:0] out_src = (bit_cnt_q == 4'h0) ? reply_q : shift_out_q;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_prev_q <= 1'b1;
      cs_prev_q <= 1'b1;
      shift_in_q <= 16'h0000;
      shift_out_q <= 16'h0000;
      bit_cnt_q <= 4'h0;
      miso_q <= 1'b0;
      cmd_valid_q <= 1'b0;
    end else begin
      sclk_prev_q <= pin_q[0];
      cs_prev_q <= pin_q[1];
      cmd_valid_q <= word_done;
      if (cs_fall) begin
        bit_cnt_q <= 4'h0;
      end else if (sclk_rise) begin
        shift_in_q <= {shift_in_q[14:0], pin_q[2]};
        bit_cnt_q <= bit_cnt_q + 4'h1;
      end else if (sclk_fall) begin
        miso_q <= out_src[15];
        shift_out_q <= {out_src[14:0], 1'b0};
      end
    end
  end
  assign spi_miso = miso_q;

  // =======================================
  // command decode
  ird_pkg::ird_cmd_t cmd;
  assign cmd = shift_in_q;
  wire logic wr_en = cmd_valid_q && cmd.wr;
  wire logic rd_en = cmd_valid_q && !cmd.wr;
  wire logic hi = cmd.addr[0];
  wire logic [6:0] word_addr = {cmd.addr[6:1], 1'b0};
  wire logic wr_sens = wr_en && word_addr == ird_pkg::ADDR_RANGE_TAPS;
  wire logic wr_gpio = wr_en && word_addr == ird_pkg::ADDR_IO_LINE;
  wire logic wr_misc = wr_en && word_addr == ird_pkg::ADDR_MISC;
  wire logic wr_aux = wr_en && word_addr == ird_pkg::ADDR_ANALOG_OUT;
  wire logic wr_smpl = wr_en && word_addr == ird_pkg::ADDR_SAMPLE;
  wire logic wr_glob = wr_en && word_addr == ird_pkg::ADDR_GLOBAL;

  function automatic logic [15:0] put_byte(input logic [15:0] old, input logic sel_hi,
                                           input logic [7:0] d, input logic [15:0] m);
    put_byte = (sel_hi ? {d, old[7:0]} : {old[15:8], d}) & m;
  endfunction

  // =======================================
  // registers
  logic [15:0] sens_q;
  logic [15:0] gpio_q;
  logic [15:0] misc_q;
  logic [15:0] aux_q;
  logic [15:0] smpl_q;
  logic [15:0] glob_q;
  logic [11:0] dac_q;
  wire logic [1:0] test_done;

  // range write may raise the taps to the floor of the new range
  wire logic [15:0] sens_w = wr_sens ?
    put_byte(sens_q, hi, cmd.data, ird_pkg::MASK_RANGE_TAPS) : sens_q;
  wire logic [2:0] range_w = sens_w[ird_pkg::RANGE_LSB +: 3];
  wire logic [2:0] tap_floor = (range_w == ird_pkg::RANGE_CODE_MID) ? ird_pkg::TAPS_MIN_MID :
    (range_w == ird_pkg::RANGE_CODE_NARROW) ? ird_pkg::TAPS_MIN_NARROW :
    ird_pkg::TAPS_MIN_NONE;
  wire logic [2:0] taps_fix = (sens_w[2:0] < tap_floor) ? tap_floor : sens_w[2:0];
  wire logic [15:0] sens_d = {sens_w[15:3], taps_fix};

  wire logic [15:0] gpio_d = wr_gpio ?
    put_byte(gpio_q, hi, cmd.data, ird_pkg::MASK_IO_LINE) : gpio_q;

  // test bits: hardware clear loses against a write of 1 in the same cycle
  wire logic [15:0] misc_w = wr_misc ?
    put_byte(misc_q, hi, cmd.data, ird_pkg::MASK_MISC) : misc_q;
  wire logic [1:0] test_set = (wr_misc && hi) ? cmd.data[3:2] : 2'h0;
  wire logic [1:0] test_keep = ~(test_done & ~test_set);
  wire logic [15:0] misc_d = {misc_w[15:12], misc_w[11:10] & test_keep, misc_w[9:0]};

  wire logic [15:0] aux_d = wr_aux ?
    put_byte(aux_q, hi, cmd.data, ird_pkg::MASK_ANALOG_OUT) : aux_q;
  wire logic [15:0] smpl_d = wr_smpl ?
    put_byte(smpl_q, hi, cmd.data, ird_pkg::MASK_SAMPLE) : smpl_q;
  // global triggers finish in one cycle, so they clear next edge
  wire logic [15:0] glob_d = wr_glob ?
    put_byte(16'h0000, hi, cmd.data, ird_pkg::MASK_GLOBAL) : 16'h0000;
  wire logic dac_latch = glob_q[ird_pkg::GLOBAL_DAC_LATCH];

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sens_q <= ird_pkg::RST_RANGE_TAPS;
      gpio_q <= ird_pkg::RST_IO_LINE;
      misc_q <= ird_pkg::RST_MISC;
      aux_q <= ird_pkg::RST_ANALOG_OUT;
      smpl_q <= ird_pkg::RST_SAMPLE;
      glob_q <= ird_pkg::RST_GLOBAL;
      dac_q <= 12'h000;
    end else begin
      sens_q <= sens_d;
      gpio_q <= gpio_d;
      misc_q <= misc_d;
      aux_q <= aux_d;
      smpl_q <= smpl_d;
      glob_q <= glob_d;
      if (dac_latch) begin
        dac_q <= aux_q[11:0];
      end
    end
  end

  // =======================================
  // self-test (index 0) and flash test (index 1) timers
  for (genvar g = 0; g < 2; g++) begin : g_test
    localparam int T_CYC = (g == 1) ? ird_pkg::FLASH_TEST_CYCLES : ird_pkg::SELF_TEST_CYCLES;
    localparam logic [11:0] T_LAST = 12'(T_CYC - 1);
    logic [11:0] cnt_q;
    logic [11:0] held_q;
    wire logic run = misc_q[ird_pkg::MISC_SELF_TEST + g];
    assign test_done[g] = run && cnt_q == T_LAST;
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        cnt_q <= 12'h000;
      end else if (!run || test_done[g]) begin
        cnt_q <= 12'h000;
      end else begin
        cnt_q <= cnt_q + 12'h001;
      end
    end
    // cycles the bit has stood since set or restarted
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        held_q <= 12'h000;
      end else begin
        held_q <= (run && !(test_done[g] && test_set[g])) ? held_q + 12'h001 : 12'h000;
      end
    end
    a_test_bit_ends: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      run |-> held_q <= T_LAST)
      else $error("test bit not cleared on completion");
  end

  // =======================================
  // sample timing, internal period or external clock on line four
  logic [19:0] base_cnt_q;
  logic [6:0] inc_cnt_q;
  logic line4_prev_q;
  logic tick_q;
  wire logic [19:0] base_last = smpl_q[ird_pkg::SAMPLE_BASE] ?
    20'(TB_SLOW_CYCLES - 1) : 20'(TB_FAST_CYCLES - 1);
  wire logic base_wrap = base_cnt_q >= base_last;
  wire logic inc_wrap = inc_cnt_q >= smpl_q[6:0];
  wire logic ext_mode = smpl_q[7:0] == 8'h00 && !gpio_q[ird_pkg::IO_LINE_FOUR];
  wire logic ext_edge = pin_q[6] && !line4_prev_q;
  wire logic tick_d = ext_mode ? ext_edge : (base_wrap && inc_wrap);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      base_cnt_q <= 20'h0_0000;
      inc_cnt_q <= 7'h00;
      line4_prev_q <= 1'b0;
      tick_q <= 1'b0;
    end else begin
      line4_prev_q <= pin_q[6];
      tick_q <= tick_d;
      base_cnt_q <= (ext_mode || base_wrap) ? 20'h0_0000 : base_cnt_q + 20'h0_0001;
      if (ext_mode || (base_wrap && inc_wrap)) begin
        inc_cnt_q <= 7'h00;
      end else if (base_wrap) begin
        inc_cnt_q <= inc_cnt_q + 7'h01;
      end
    end
  end
  assign sample_tick = tick_q;

  // =======================================
  // data-ready pulse and io line ownership
  logic dr_pulse;
  ird_pulse_gen #(
    .PULSE_CYCLES(DR_PULSE_CYCLES)
  ) u_pulse (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .trigger(tick_q),
    .pulse(dr_pulse)
  );
  wire logic dr_level = dr_pulse ~^ misc_q[ird_pkg::MISC_DR_POL];
  wire logic [3:0] dr_own;
  wire logic [3:0] io_out_d;
  wire logic [3:0] io_oe_n_d;
  wire logic [3:0] level_rd;
  logic [3:0] io_out_q;
  logic [3:0] io_oe_n_q;

  for (genvar i = 0; i < 4; i++) begin : g_line
    assign dr_own[i] = misc_q[ird_pkg::MISC_DR_EN] &&
      (misc_q[ird_pkg::MISC_DR_SEL] ? (i == 1) : (i == 0));
    assign io_out_d[i] = dr_own[i] ? dr_level : alarm_own[i] ? alarm_level[i] :
      gpio_q[ird_pkg::IO_LEVEL_LSB + i];
    assign io_oe_n_d[i] = !(dr_own[i] || alarm_own[i] || gpio_q[i]);
    assign level_rd[i] = gpio_q[i] ? gpio_q[ird_pkg::IO_LEVEL_LSB + i] : pin_q[3 + i];

    a_line_direction: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      gpio_q[i] && !dr_own[i] && !alarm_own[i] |=>
        !io_oe_n[i] && io_out[i] == $past(gpio_q[ird_pkg::IO_LEVEL_LSB + i]))
      else $error("output line not driven with its level");
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      io_out_q <= 4'h0;
      io_oe_n_q <= 4'hF;
    end else begin
      io_out_q <= io_out_d;
      io_oe_n_q <= io_oe_n_d;
    end
  end
  assign io_out = io_out_q;
  assign io_oe_n = io_oe_n_q;

  // =======================================
  // read back, answered in the next word
  wire logic [15:0] gpio_rd = {gpio_q[15:12], level_rd, gpio_q[7:0]};
  wire logic [15:0] rd_data =
    (word_addr == ird_pkg::ADDR_RANGE_TAPS) ? sens_q :
    (word_addr == ird_pkg::ADDR_IO_LINE) ? gpio_rd :
    (word_addr == ird_pkg::ADDR_MISC) ? misc_q :
    (word_addr == ird_pkg::ADDR_ANALOG_OUT) ? aux_q :
    (word_addr == ird_pkg::ADDR_SAMPLE) ? smpl_q :
    (word_addr == ird_pkg::ADDR_GLOBAL) ? glob_q : 16'h0000;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reply_q <= 16'h0000;
    end else if (rd_en) begin
      reply_q <= rd_data;
    end else if (wr_en) begin
      reply_q <= 16'h0000;
    end
  end

  // =======================================
  // function outputs
  wire logic [2:0] range_q = sens_q[ird_pkg::RANGE_LSB +: 3];
  assign gyro_range = (range_q == ird_pkg::RANGE_CODE_WIDE) ? ird_pkg::RANGE_WIDE :
    (range_q == ird_pkg::RANGE_CODE_MID) ? ird_pkg::RANGE_MID :
    (range_q == ird_pkg::RANGE_CODE_NARROW) ? ird_pkg::RANGE_NARROW :
    ird_pkg::RANGE_BAD;
  assign stage_taps = 8'h01 << sens_q[2:0];
  assign st_neg_en = misc_q[ird_pkg::MISC_ST_NEG];
  assign st_pos_en = misc_q[ird_pkg::MISC_ST_POS];
  assign lin_bias_comp_en = misc_q[ird_pkg::MISC_LIN_BIAS];
  assign accel_align_en = misc_q[ird_pkg::MISC_ACCEL_ALIGN];
  assign self_test_busy = misc_q[ird_pkg::MISC_SELF_TEST];
  assign flash_test_busy = misc_q[ird_pkg::MISC_SELF_TEST + 1];
  assign global_pulse = glob_q[7:0];
  assign dac_code = dac_q;

  // =======================================
  // checks
  a_tap_floor_mid: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    range_q == ird_pkg::RANGE_CODE_MID |-> sens_q[2:0] >= ird_pkg::TAPS_MIN_MID)
    else $error("middle range below tap floor");

  a_tap_floor_narrow: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    range_q == ird_pkg::RANGE_CODE_NARROW |-> sens_q[2:0] >= ird_pkg::TAPS_MIN_NARROW)
    else $error("narrow range below tap floor");

  a_range_decode: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    range_q == ird_pkg::RANGE_CODE_WIDE |-> gyro_range == ird_pkg::RANGE_WIDE)
    else $error("wide range misdecoded");

  a_dr_line_level: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    misc_q[ird_pkg::MISC_DR_EN] && !misc_q[ird_pkg::MISC_DR_SEL] |=>
      !io_oe_n[0] && io_out[0] == ($past(dr_pulse) ~^ $past(misc_q[ird_pkg::MISC_DR_POL])))
    else $error("data-ready not on line one");

  a_dac_latch_copy: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    dac_latch |=> dac_code == $past(aux_q[11:0]))
    else $error("dac latch did not copy");

  a_dac_hold: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !dac_latch |=> $stable(dac_code))
    else $error("dac changed without latch");

  a_glob_self_clear: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    glob_q != 16'h0000 && !wr_glob |=> glob_q == 16'h0000)
    else $error("global trigger did not clear");

  a_ext_sample_edge: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    ext_mode && ext_edge |=> sample_tick ##1 !sample_tick)
    else $error("external clock edge missed");
endmodule
`default_nettype wire

// >>> dv/ird_spi_host.sv
// Purpose: host model driving the spi command port, mode 3
// Assumes: sclk half period of 10 core cycles
// Notes: mosi shows the inverse of its last bit while idle
`default_nettype none
module ird_spi_host (
  input wire logic core_clk, // core clock
  input wire logic miso, // serial data from device
  output logic sclk, // serial clock, idle high
  output logic cs_n, // select, low active
  output logic mosi // serial data to device
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // =======================================
  // one 16-bit word, msb first, reply bits sampled at rise
  // write word carries top bit, byte address, data byte
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    @(posedge core_clk);
    #1 cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      repeat (10) @(posedge core_clk);
      #1 sclk = 1'b0;
      mosi = w[i];
      repeat (10) @(posedge core_clk);
      #1 sclk = 1'b1;
      r[i] = miso;
    end
    repeat (10) @(posedge core_clk);
    #1 cs_n = 1'b1;
    mosi = ~w[0];
    repeat (10) @(posedge core_clk);
    #1;
  endtask
endmodule
`default_nettype wire

// >>> dv/ird_io_range_dac_control_tb.sv
// Purpose: self-checking bench of the control bank
// Assumes: shortened pulse and time base counts
// Notes: random values from a fixed seed
`default_nettype none
module ird_io_range_dac_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic sclk, cs_n, mosi, miso, st_neg_en, st_pos_en, lin_bias, align, st_busy, fl_busy;
  logic [3:0] io_in = 4'h0, alarm_own = 4'h0, alarm_level = 4'h0, io_out, io_oe_n, d, l;
  ird_pkg::ird_range_t gyro_range;
  logic [7:0] stage_taps, gp;
  logic tick;
  logic [11:0] dac_code;
  logic [15:0] r, v;
  logic [2:0] m, f;
  logic [2:0] rgs [3] = '{3'h4, 3'h2, 3'h1};
  ird_pkg::ird_range_t rdec [3] = '{ird_pkg::RANGE_WIDE, ird_pkg::RANGE_MID, ird_pkg::RANGE_NARROW};
  int error_cnt = 0;
  int n_tests = 0;
  int seed = 66;
  int w;
  int tick_cnt = 0;
  int gp_cnt = 0;
  always #12.5 core_clk = ~core_clk;
  ird_spi_host host (.core_clk(core_clk), .miso(miso), .sclk(sclk), .cs_n(cs_n), .mosi(mosi));
  ird_io_range_dac_control #(.DR_PULSE_CYCLES(20), .TB_FAST_CYCLES(50), .TB_SLOW_CYCLES(200))
    uut (.core_clk(core_clk), .reset_n(reset_n), .spi_sclk(sclk), .spi_cs_n(cs_n),
    .spi_mosi(mosi), .spi_miso(miso), .io_in(io_in), .io_out(io_out), .io_oe_n(io_oe_n),
    .alarm_own(alarm_own), .alarm_level(alarm_level), .gyro_range(gyro_range),
    .stage_taps(stage_taps), .st_neg_en(st_neg_en), .st_pos_en(st_pos_en),
    .lin_bias_comp_en(lin_bias), .accel_align_en(align), .self_test_busy(st_busy),
    .flash_test_busy(fl_busy), .global_pulse(gp), .dac_code(dac_code), .sample_tick(tick));
  // one-cycle outputs counted where settled
  always @(negedge core_clk) begin
    if (tick === 1'b1) tick_cnt++;
    if (gp === 8'h04) gp_cnt++;
  end
  // =======================================
  // helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] dt);
    host.xfer({1'b1, a, dt}, r);
  endtask
  task automatic rd(input logic [6:0] a, output logic [15:0] dt);
    host.xfer({1'b0, a, 8'h00}, r);
    host.xfer(16'h0000, dt);
  endtask
  task automatic pulse_w(input int b, input logic act, output int n);
    n = 0;
    repeat (40) if (io_out[b] === act) begin
      @(posedge core_clk);
      #1;
    end
    repeat (300) begin
      @(posedge core_clk);
      #1;
      if (io_out[b] === act) n++;
      else if (n > 0) break;
    end
  endtask
  function automatic logic [2:0] floor_taps(input logic [2:0] rg, input logic [2:0] t);
    if (rg == 3'h2 && t < 3'h2) return 3'h2;
    if (rg == 3'h1 && t < 3'h4) return 3'h4;
    return t;
  endfunction
  task automatic summarize;
    $display("errors=%0d checks=%0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // =======================================
  // watchdog, well above the expected run
  initial begin
    repeat (60000) @(posedge core_clk);
    error_cnt++;
    summarize();
  end
  // =======================================
  // scenarios
  initial begin
    repeat (2) @(posedge core_clk);
    #1 reset_n = 1'b1;
    repeat (10) @(posedge core_clk);
    rd(ird_pkg::ADDR_RANGE_TAPS, v); check(v, 16'h0402);
    rd(ird_pkg::ADDR_MISC, v); check(v, 16'h0006);
    check({12'h0, io_oe_n}, 16'h000E);
    pulse_w(0, 1'b1, w); check(16'(w), 16'd20);
    wr(ird_pkg::ADDR_MISC, 8'h05);
    check({12'h0, io_oe_n}, 16'h000D);
    pulse_w(1, 1'b0, w); check(16'(w), 16'd20);
    for (int k = 0; k < 6; k++) begin
      m = 3'($random(seed));
      f = floor_taps(rgs[k % 3], m);
      wr(ird_pkg::ADDR_RANGE_TAPS + 7'h1, {5'h0, rgs[k % 3]});
      wr(ird_pkg::ADDR_RANGE_TAPS, {5'h0, m});
      rd(ird_pkg::ADDR_RANGE_TAPS, v);
      check(v, {5'h0, rgs[k % 3], 5'h0, f});
      check(16'(gyro_range), 16'(rdec[k % 3]));
      check({8'h0, stage_taps}, 16'h0001 << f);
    end
    v = 16'($random(seed)) & 16'h0FFF;
    wr(ird_pkg::ADDR_ANALOG_OUT, v[7:0]);
    wr(ird_pkg::ADDR_ANALOG_OUT + 7'h1, v[15:8]);
    check({4'h0, dac_code}, 16'h0000);
    wr(ird_pkg::ADDR_GLOBAL, 8'h04);
    check(16'(gp_cnt), 16'h0001);
    check({4'h0, dac_code}, v);
    rd(ird_pkg::ADDR_GLOBAL, v); check(v, 16'h0000);
    wr(ird_pkg::ADDR_MISC, 8'h00);
    for (int k = 0; k < 4; k++) begin
      d = 4'($random(seed));
      l = 4'($random(seed));
      io_in = 4'($random(seed));
      wr(ird_pkg::ADDR_IO_LINE + 7'h1, {4'h0, l});
      wr(ird_pkg::ADDR_IO_LINE, {4'h0, d});
      check({12'h0, io_oe_n}, {12'h0, ~d});
      check({12'h0, io_out & d}, {12'h0, l & d});
      rd(ird_pkg::ADDR_IO_LINE, v);
      check(v, {4'h0, (l & d) | (io_in & ~d), 4'h0, d});
    end
    alarm_own = 4'hF;
    alarm_level = ~l;
    repeat (3) @(posedge core_clk);
    #1 check({8'h0, io_oe_n, io_out}, {12'h0, ~l});
    alarm_own = 4'h0;
    wr(ird_pkg::ADDR_IO_LINE, 8'h00);
    wr(ird_pkg::ADDR_SAMPLE, 8'h00);
    w = tick_cnt;
    for (int k = 0; k < 3; k++) begin
      io_in[3] = 1'b0;
      repeat (20) @(posedge core_clk);
      #1 io_in[3] = 1'b1;
      repeat (20) @(posedge core_clk);
      #1;
    end
    check(16'(tick_cnt - w), 16'h0003);
    wr(ird_pkg::ADDR_MISC + 7'h1, 8'h0F);
    wr(ird_pkg::ADDR_MISC, 8'hC0);
    check({12'h0, fl_busy, st_busy, st_neg_en, st_pos_en}, 16'h000F);
    check({14'h0, lin_bias, align}, 16'h0003);
    repeat (2100) @(posedge core_clk);
    rd(ird_pkg::ADDR_MISC, v); check(v, 16'h03C0);
    summarize();
  end
endmodule
`default_nettype wire
